// ### design/ctu_params.svh
`ifndef CTU_PARAMS_SVH
`define CTU_PARAMS_SVH
`define CTU_GRP_BREAK 2'h0
`define CTU_GRP_ERR 2'h1
`define CTU_GRP_SYS 2'h2
`define CTU_GRP_SCHED 2'h3
`define CTU_BIT_BREAK 0
`define CTU_BIT_INTCHK 1
`define CTU_BIT_OVF 2
`define CTU_BIT_BADINS 3
`define CTU_BIT_RDICP 4
`define CTU_BIT_WRICP 5
`define CTU_BIT_SCHED_LO 6
`define CTU_BIT_SCHED_HI 13
`define CTU_BIT_READY_HI 11
`define CTU_BIT_SWERR 15
`define CTU_W_ENABLES 2'h0
`define CTU_W_STATUS 2'h1
`define CTU_W_WPTR 2'h2
`define CTU_W_IPTR 2'h3
`define CTU_SCHED_WORD0 32'h0
`define CTU_STRUCT_BYTES 32'h10
`define CTU_ENABLES_RST 32'h0
`define CTU_STATUS_RST 16'h0
`define CTU_BASE_RST 32'h0
`define CTU_OFF_BASE 12'h000
`define CTU_OFF_EN0 12'h004
`define CTU_OFF_EN1 12'h008
`define CTU_OFF_ST0 12'h00c
`define CTU_OFF_ST1 12'h010
`define CTU_OFF_INFO 12'h014
`endif

// ### design/ctu_pkg.sv
package ctu_pkg;
  typedef struct packed {
    logic [31:0] iptr;
    logic [31:0] wptr;
    logic [31:0] status;
    logic [31:0] enables;
  } ctu_state_t;
  typedef struct packed {
    logic brk;
    logic int_check_fault;
    logic ovf;
    logic bad_instruction_fault;
    logic handler_read_intercept;
    logic handler_write_intercept;
    logic [7:0] sched;
  } ctu_cause_t;
  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } ctu_mreq_t;
  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001,
    S_SAVE = 7'b0000010,
    S_LOAD = 7'b0000100,
    S_SCHED = 7'b0001000,
    S_DONE = 7'b0010000,
    S_RET = 7'b0100000,
    S_RDONE = 7'b1000000
  } ctu_state_e_t;
endpackage

// ### design/ctu_word_port.sv
`timescale 1ns/1ps
`default_nettype none
module ctu_word_port
  import ctu_pkg::*;
(
  // Clock and reset.
  input wire logic CLK_I,
  input wire logic RESET_I,
  // Request from the sequencer.
  input wire logic go_i,
  input wire logic we_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  output logic done_o,
  output logic [31:0] rdata_o,
  // Memory side.
  output ctu_mreq_t mem_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i
);
  // Holds one word request until the memory acknowledges it.
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      mem_o <= '0;
    end else if (go_i) begin
      mem_o <= '{req: 1'b1, we: we_i, addr: addr_i, wdata: wdata_i};
    end else if (mem_o.req && mem_ack_i) begin
      mem_o.req <= 1'b0;
    end
  end
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      done_o <= 1'b0;
      rdata_o <= 32'h0;
    end else begin
      done_o <= mem_o.req && mem_ack_i;
      if (mem_o.req && mem_ack_i && !mem_o.we) begin
        rdata_o <= mem_rdata_i;
      end
    end
  end
endmodule
`default_nettype wire

// ### design/ctu_trap_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "ctu_params.svh"
module ctu_trap_unit
  import ctu_pkg::*;
(
  // Clock and reset.
  input wire logic CLK_I,
  input wire logic RESET_I,
  // APB register port.
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Cause events from execution and scheduler.
  input wire logic CAUSE_PRI_I,
  input wire ctu_cause_t CAUSE_I,
  input wire logic SW_CAUSE_I,
  input wire logic [3:0] SW_CAUSE_BIT_I,
  input wire logic SCHED_HAS_WPTR_I,
  input wire logic [31:0] SCHED_WPTR_I,
  // Running process state.
  input wire logic TRAP_POINT_I,
  input wire logic PRI_I,
  input wire logic [31:0] NEXT_IPTR_I,
  input wire logic [31:0] WPTR_I,
  input wire logic [31:0] STATUS_I,
  input wire logic TRET_I,
  // Enable and disable operations.
  input wire logic EN_OP_I,
  input wire logic EN_SET_I,
  input wire logic EN_PRI_I,
  input wire logic [15:0] EN_MASK_I,
  output logic [15:0] EN_PREV_O,
  // Intercept indications for the transfer instructions.
  output logic RD_BLOCK_O,
  output logic WR_BLOCK_O,
  // State handed back to the core.
  output logic BUSY_O,
  output logic LOAD_VALID_O,
  output ctu_state_t LOAD_STATE_O,
  output logic [1:0] GROUP_O,
  output logic [3:0] CAUSE_O,
  // Memory port for the trap structures.
  output ctu_mreq_t MEM_O,
  input wire logic MEM_ACK_I,
  input wire logic [31:0] MEM_RDATA_I
);
  ctu_state_e_t state;
  logic [31:0] base;
  logic [31:0] en_q [0:1];
  logic [15:0] st_q [0:1];
  logic [1:0] svc_q;
  logic [3:0] svc_cause [0:1];
  logic [31:0] rd_q [0:3];
  logic [31:0] sched_wptr;
  logic [1:0] sched_has;
  logic pri;
  logic [3:0] cause;
  logic [1:0] idx;
  logic issued;
  ctu_state_t cur;
  logic go;
  logic we;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic done;
  logic [31:0] rdata;
  logic [15:0] ev;
  logic [13:0] pend;
  logic take;
  logic apb_wr;
  logic [15:0] w1c;
  logic [31:0] next_rdata;
  logic slv_err;

  function automatic logic [1:0] group_of(input logic [3:0] c);
    if (c == 4'h0) begin
      group_of = `CTU_GRP_BREAK;
    end else if (c <= 4'h2) begin
      group_of = `CTU_GRP_ERR;
    end else if (c <= 4'h5) begin
      group_of = `CTU_GRP_SYS;
    end else begin
      group_of = `CTU_GRP_SCHED;
    end
  endfunction

  function automatic logic [3:0] lowest(input logic [13:0] v);
    lowest = 4'h0;
    for (int i = 13; i >= 0; i--) begin
      if (v[i]) begin
        lowest = 4'(i);
      end
    end
  endfunction

  // Structure address per priority and group; trapped follows handler.
  function automatic logic [31:0] struct_addr(input logic [31:0] b, input logic p,
      input logic [1:0] g, input logic trapped, input logic [1:0] w);
    struct_addr = b + `CTU_STRUCT_BYTES * {27'h0, p, g, trapped, 1'b0}
      + {28'h0, w, 2'b00};
  endfunction

  // Raw events in cause bit order; bits 0 to 13 are recorded only when enabled, bit 15 when the software cause's bit is enabled.
  always_comb begin
    ev = '0;
    ev[`CTU_BIT_BREAK] = CAUSE_I.brk;
    ev[`CTU_BIT_INTCHK] = CAUSE_I.int_check_fault;
    ev[`CTU_BIT_OVF] = CAUSE_I.ovf;
    ev[`CTU_BIT_BADINS] = CAUSE_I.bad_instruction_fault;
    ev[`CTU_BIT_RDICP] = CAUSE_I.handler_read_intercept;
    ev[`CTU_BIT_WRICP] = CAUSE_I.handler_write_intercept;
    ev[`CTU_BIT_SCHED_HI:`CTU_BIT_SCHED_LO] = CAUSE_I.sched;
    if (SW_CAUSE_I && SW_CAUSE_BIT_I <= 4'hd) begin
      ev[SW_CAUSE_BIT_I] = 1'b1;
    end
    ev = ev & en_q[CAUSE_PRI_I][15:0];
    ev[`CTU_BIT_SWERR] = SW_CAUSE_I && ev[SW_CAUSE_BIT_I];
  end

  assign RD_BLOCK_O = en_q[PRI_I][`CTU_BIT_RDICP];
  assign WR_BLOCK_O = en_q[PRI_I][`CTU_BIT_WRICP];
  assign pend = st_q[PRI_I][13:0] & en_q[PRI_I][13:0];
  assign take = (state == S_IDLE) && !TRET_I && TRAP_POINT_I && !svc_q[PRI_I]
    && (|pend);
  assign apb_wr = PSEL_I && PENABLE_I && PWRITE_I;
  assign w1c = PWDATA_I[15:0];
  assign BUSY_O = (state != S_IDLE);

  // Per-priority status: hardware set wins over software or return clear.
  for (genvar p = 0; p < 2; p++) begin : g_pri
    always_ff @(posedge CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
        st_q[p] <= `CTU_STATUS_RST;
      end else begin
        st_q[p] <= (st_q[p]
          & ~((apb_wr && PADDR_I == (p == 0 ? `CTU_OFF_ST0 : `CTU_OFF_ST1)) ? w1c : 16'h0)
          & ~((state == S_RDONE && pri == 1'(p)) ?
              (16'h8000 | (16'h1 << cause)) : 16'h0))
          | ((CAUSE_PRI_I == 1'(p)) ? ev : 16'h0);
      end
    end
  end

  // Enables registers: operations, handler AND, return restore, then software.
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      en_q[0] <= `CTU_ENABLES_RST;
      en_q[1] <= `CTU_ENABLES_RST;
      EN_PREV_O <= 16'h0;
    end else if (EN_OP_I) begin
      EN_PREV_O <= en_q[EN_PRI_I][15:0];
      if (EN_SET_I) begin
        en_q[EN_PRI_I][15:0] <= en_q[EN_PRI_I][15:0] | EN_MASK_I;
      end else begin
        en_q[EN_PRI_I][15:0] <= en_q[EN_PRI_I][15:0] & ~EN_MASK_I;
      end
    end else if (state == S_DONE) begin
      en_q[pri] <= en_q[pri] & rd_q[`CTU_W_ENABLES];
    end else if (state == S_RDONE) begin
      en_q[pri] <= rd_q[`CTU_W_ENABLES];
    end else if (apb_wr && PADDR_I == `CTU_OFF_EN0) begin
      en_q[0] <= PWDATA_I;
    end else if (apb_wr && PADDR_I == `CTU_OFF_EN1) begin
      en_q[1] <= PWDATA_I;
    end
  end

  // Structure base register.
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      base <= `CTU_BASE_RST;
    end else if (apb_wr && PADDR_I == `CTU_OFF_BASE) begin
      base <= PWDATA_I;
    end
  end

  // Workspace of the most recent enabled ready-process scheduler cause.
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      sched_wptr <= 32'h0;
      sched_has <= 2'b00;
    end else if (|ev[`CTU_BIT_READY_HI:`CTU_BIT_SCHED_LO] && SCHED_HAS_WPTR_I) begin
      sched_wptr <= SCHED_WPTR_I;
      sched_has[CAUSE_PRI_I] <= 1'b1;
    end else if (state == S_DONE && group_of(cause) == `CTU_GRP_SCHED) begin
      sched_has[pri] <= 1'b0;
    end
  end

  // Entry and return sequencer.
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      state <= S_IDLE;
      pri <= 1'b0;
      cause <= 4'h0;
      idx <= 2'h0;
      cur <= '0;
      svc_q <= 2'b00;
      svc_cause[0] <= 4'h0;
      svc_cause[1] <= 4'h0;
    end else begin
      case (state)
        S_IDLE: begin
          idx <= 2'h0;
          if (TRET_I && svc_q[PRI_I]) begin
            pri <= PRI_I;
            cause <= svc_cause[PRI_I];
            state <= S_RET;
          end else if (take) begin
            pri <= PRI_I;
            cause <= lowest(pend);
            svc_cause[PRI_I] <= lowest(pend);
            svc_q[PRI_I] <= 1'b1;
            // Stack registers are left to the handler code.
            cur <= '{iptr: NEXT_IPTR_I, wptr: WPTR_I,
              status: STATUS_I | (32'h1 << lowest(pend)),
              enables: en_q[PRI_I]};
            state <= S_SAVE;
          end
        end
        S_SAVE: begin
          if (done) begin
            idx <= idx + 2'h1;
            if (idx == `CTU_W_IPTR) begin
              state <= S_LOAD;
            end
          end
        end
        S_LOAD: begin
          if (done) begin
            idx <= idx + 2'h1;
            if (idx == `CTU_W_IPTR) begin
              if (group_of(cause) == `CTU_GRP_SCHED && sched_has[pri]) begin
                state <= S_SCHED;
              end else begin
                state <= S_DONE;
              end
            end
          end
        end
        S_SCHED: begin
          if (done) begin
            state <= S_DONE;
          end
        end
        S_RET: begin
          if (done) begin
            idx <= idx + 2'h1;
            if (idx == `CTU_W_IPTR) begin
              state <= S_RDONE;
            end
          end
        end
        S_RDONE: begin
          svc_q[pri] <= 1'b0;
          state <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // Captured words of the structure being read.
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      for (int i = 0; i < 4; i++) begin
        rd_q[i] <= 32'h0;
      end
    end else if (done && (state == S_LOAD || state == S_RET)) begin
      rd_q[idx] <= rdata;
    end
  end

  // One word request per step; a new one issues after the last completes.
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      issued <= 1'b0;
    end else if (go) begin
      issued <= 1'b1;
    end else if (done) begin
      issued <= 1'b0;
    end
  end

  always_comb begin
    go = !issued && !done
      && (state == S_SAVE || state == S_LOAD || state == S_SCHED || state == S_RET);
    we = (state == S_SAVE) || (state == S_SCHED);
    wdata = 32'h0;
    addr = struct_addr(base, pri, group_of(cause), 1'b0, idx);
    case (idx)
      `CTU_W_ENABLES: wdata = cur.enables;
      `CTU_W_STATUS: wdata = cur.status;
      `CTU_W_WPTR: wdata = cur.wptr;
      default: wdata = cur.iptr;
    endcase
    if (state == S_SAVE || state == S_RET) begin
      addr = struct_addr(base, pri, group_of(cause), 1'b1, idx);
    end else if (state == S_SCHED) begin
      addr = rd_q[`CTU_W_WPTR] + `CTU_SCHED_WORD0;
      wdata = sched_wptr;
    end
  end

  ctu_word_port u_port (
    .CLK_I(CLK_I),
    .RESET_I(RESET_I),
    .go_i(go),
    .we_i(we),
    .addr_i(addr),
    .wdata_i(wdata),
    .done_o(done),
    .rdata_o(rdata),
    .mem_o(MEM_O),
    .mem_ack_i(MEM_ACK_I),
    .mem_rdata_i(MEM_RDATA_I)
  );

  // Hand-over of loaded state to the core.
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      LOAD_VALID_O <= 1'b0;
      LOAD_STATE_O <= '0;
      GROUP_O <= 2'h0;
      CAUSE_O <= 4'h0;
    end else begin
      LOAD_VALID_O <= (state == S_DONE) || (state == S_RDONE);
      if (state == S_DONE) begin
        LOAD_STATE_O <= '{iptr: rd_q[`CTU_W_IPTR], wptr: rd_q[`CTU_W_WPTR],
          status: rd_q[`CTU_W_STATUS],
          enables: en_q[pri] & rd_q[`CTU_W_ENABLES]};
        GROUP_O <= group_of(cause);
        CAUSE_O <= cause;
      end else if (state == S_RDONE) begin
        LOAD_STATE_O <= '{iptr: rd_q[`CTU_W_IPTR], wptr: rd_q[`CTU_W_WPTR],
          status: rd_q[`CTU_W_STATUS] & ~(32'h8000 | (32'h1 << cause)),
          enables: rd_q[`CTU_W_ENABLES]};
        GROUP_O <= group_of(cause);
        CAUSE_O <= cause;
      end
    end
  end

  // APB read decode; answers in the access cycle.
  always_comb begin
    next_rdata = 32'h0;
    slv_err = 1'b0;
    if (PADDR_I == `CTU_OFF_BASE) begin
      next_rdata = base;
    end else if (PADDR_I == `CTU_OFF_EN0) begin
      next_rdata = en_q[0];
    end else if (PADDR_I == `CTU_OFF_EN1) begin
      next_rdata = en_q[1];
    end else if (PADDR_I == `CTU_OFF_ST0) begin
      next_rdata = {16'h0, st_q[0]};
    end else if (PADDR_I == `CTU_OFF_ST1) begin
      next_rdata = {16'h0, st_q[1]};
    end else if (PADDR_I == `CTU_OFF_INFO) begin
      next_rdata = {20'h0, svc_cause[1], svc_cause[0], svc_q, 1'b0, BUSY_O};
    end else begin
      slv_err = 1'b1;
    end
  end

  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && slv_err;

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      PRDATA_O <= 32'h0;
    end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      PRDATA_O <= next_rdata;
    end
  end
endmodule
`default_nettype wire

// ### sim/ctu_trap_unit_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ctu_trap_unit_properties
  import ctu_pkg::*;
(
  // Clock and reset.
  input wire logic CLK_I,
  input wire logic RESET_I,
  // Process state and operations.
  input wire logic TRAP_POINT_I,
  input wire logic TRET_I,
  input wire logic PRI_I,
  input wire logic EN_OP_I,
  input wire logic EN_SET_I,
  input wire logic EN_PRI_I,
  input wire logic [15:0] EN_MASK_I,
  // Observed results.
  input wire logic [15:0] EN_PREV_O,
  input wire logic RD_BLOCK_O,
  input wire logic WR_BLOCK_O,
  input wire logic BUSY_O,
  input wire logic LOAD_VALID_O,
  // Memory port.
  input wire ctu_mreq_t MEM_O,
  input wire logic MEM_ACK_I
);
  logic quiet;
  // Idle with neither a take nor a return requested.
  assign quiet = !BUSY_O && !TRET_I && !TRAP_POINT_I;
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RESET_I);
  AST_NO_TAKE_OFF_POINT:
    assert property (quiet |=> !BUSY_O)
    else $error("Sequencer started without a trap point.");
  AST_ENTRY_SAVES_FIRST:
    assert property ($rose(BUSY_O) && !$past(TRET_I) |-> ##[0:2] (MEM_O.req && MEM_O.we))
    else $error("Entry did not begin with a save write.");
  AST_RETURN_READS:
    assert property ($rose(BUSY_O) && $past(TRET_I) |-> ##[0:2] (MEM_O.req && !MEM_O.we))
    else $error("Return did not begin with a read.");
  AST_IDLE_NO_MEM:
    assert property (!BUSY_O |-> !MEM_O.req)
    else $error("Memory request while idle.");
  AST_REQ_HELD:
    assert property (MEM_O.req && !MEM_ACK_I |=> MEM_O.req && $stable(MEM_O.addr)
                     && $stable(MEM_O.we) && $stable(MEM_O.wdata))
    else $error("Memory request changed before its answer.");
  AST_LOAD_ONE_CYCLE:
    assert property (LOAD_VALID_O |=> !LOAD_VALID_O)
    else $error("Load strobe longer than one cycle.");
  AST_RD_BLOCK_SET:
    assert property (quiet && EN_OP_I && EN_SET_I && EN_MASK_I[4] && EN_PRI_I == PRI_I
                     ##1 $stable(PRI_I) |-> RD_BLOCK_O)
    else $error("Read intercept not enabled by set op.");
  AST_WR_BLOCK_CLR:
    assert property (quiet && EN_OP_I && !EN_SET_I && EN_MASK_I[5] && EN_PRI_I == PRI_I
                     ##1 $stable(PRI_I) |-> !WR_BLOCK_O)
    else $error("Write intercept not cleared by clear op.");
  AST_PREV_HOLDS_SET:
    assert property (quiet && EN_OP_I && EN_SET_I ##1 EN_OP_I && $stable(EN_PRI_I)
                     |=> (EN_PREV_O & $past(EN_MASK_I, 2)) == $past(EN_MASK_I, 2))
    else $error("Previous mask lacks bits just set.");
  COV_LOAD: cover property (LOAD_VALID_O);
  COV_SAVE_WRITE: cover property (MEM_O.req && MEM_ACK_I && MEM_O.we);
  COV_BACK_TO_BACK_OPS: cover property (EN_OP_I ##1 EN_OP_I);
endmodule
`default_nettype wire

// ### sim/ctu_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ctu_mem_model
  import ctu_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Memory port.
  input wire ctu_mreq_t mem_i,
  output logic ack_o,
  output logic [31:0] rdata_o
);
  logic [31:0] mem [logic [31:0]];
  int unsigned wait_cnt;
  // Words never written read back a pattern made from their address.
  function automatic logic [31:0] pat(input logic [31:0] a);
    return {a[15:0], ~a[15:0]};
  endfunction
  // Answers each request once after zero to three cycles; read data toggles
  // outside the answer cycle so that a late sample is caught.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      rdata_o <= 32'h0;
      wait_cnt <= 0;
    end else begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (mem_i.req && !ack_o) begin
        if (wait_cnt == 0) begin
          ack_o <= 1'b1;
          wait_cnt <= $urandom_range(3);
          if (mem_i.we) begin
            mem[mem_i.addr] = mem_i.wdata;
          end else begin
            rdata_o <= mem.exists(mem_i.addr) ? mem[mem_i.addr] : pat(mem_i.addr);
          end
        end else begin
          wait_cnt <= wait_cnt - 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) chk_val(nm, 128'(e), 128'(a))
module tb;
  import ctu_pkg::*;
  logic CLK_I, RESET_I, PSEL_I, PENABLE_I, PWRITE_I, PREADY_O, PSLVERR_O, CAUSE_PRI_I;
  logic SW_CAUSE_I, SCHED_HAS_WPTR_I, TRAP_POINT_I, PRI_I, TRET_I, EN_OP_I, EN_SET_I;
  logic EN_PRI_I, RD_BLOCK_O, WR_BLOCK_O, BUSY_O, LOAD_VALID_O, MEM_ACK_I, en_d;
  logic [11:0] PADDR_I;
  logic [31:0] PWDATA_I, PRDATA_O, SCHED_WPTR_I, NEXT_IPTR_I, WPTR_I, STATUS_I, MEM_RDATA_I;
  logic [3:0] SW_CAUSE_BIT_I, CAUSE_O;
  logic [15:0] EN_MASK_I, EN_PREV_O;
  logic [1:0] GROUP_O;
  ctu_cause_t CAUSE_I;
  ctu_state_t LOAD_STATE_O;
  ctu_mreq_t MEM_O;
  logic [32:0] rq[$];
  logic [63:0] wq[$];
  ctu_state_t lq[$];
  logic [15:0] pq[$];
  logic [31:0] ten[2] = '{32'h0, 32'h0};
  logic [15:0] tst[2] = '{16'h0, 16'h0};
  logic [31:0] base = 32'h0;
  logic [31:0] swp = 32'h0;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  int cs[4] = '{2, 7, 12, 5};

  ctu_trap_unit dut (.CLK_I, .RESET_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I,
    .PRDATA_O, .PREADY_O, .PSLVERR_O, .CAUSE_PRI_I, .CAUSE_I, .SW_CAUSE_I, .SW_CAUSE_BIT_I,
    .SCHED_HAS_WPTR_I, .SCHED_WPTR_I, .TRAP_POINT_I, .PRI_I, .NEXT_IPTR_I, .WPTR_I,
    .STATUS_I, .TRET_I, .EN_OP_I, .EN_SET_I, .EN_PRI_I, .EN_MASK_I, .EN_PREV_O,
    .RD_BLOCK_O, .WR_BLOCK_O, .BUSY_O, .LOAD_VALID_O, .LOAD_STATE_O, .GROUP_O, .CAUSE_O,
    .MEM_O, .MEM_ACK_I, .MEM_RDATA_I);
  ctu_mem_model u_mem (.clk_i(CLK_I), .rst_i(RESET_I), .mem_i(MEM_O), .ack_o(MEM_ACK_I),
    .rdata_o(MEM_RDATA_I));

  function automatic logic [31:0] pat(input logic [31:0] a);
    return {a[15:0], ~a[15:0]};
  endfunction
  function automatic logic [13:0] cv(input int k);
    logic [13:0] v;
    v = '0;
    if (k >= 6) v[k - 6] = 1'b1;
    else v[13 - k] = 1'b1;
    return v;
  endfunction
  function automatic logic [1:0] grp(input int k);
    return (k == 0) ? 2'h0 : (k < 3) ? 2'h1 : (k < 6) ? 2'h2 : 2'h3;
  endfunction
  task automatic chk_val(input string nm, input logic [127:0] e, input logic [127:0] a);
    n_checks++;
    if (e !== a) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, a);
    end
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d.", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    if (!w) rq.push_back(e);
    PSEL_I <= 1'b1;
    PENABLE_I <= 1'b0;
    PWRITE_I <= w;
    PADDR_I <= a;
    PWDATA_I <= d;
    @(posedge CLK_I);
    PENABLE_I <= 1'b1;
    @(posedge CLK_I);
    while (!PREADY_O) @(posedge CLK_I);
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
    @(posedge CLK_I);
  endtask
  task automatic enop(input logic p, input logic s, input logic [15:0] m);
    pq.push_back(ten[p][15:0]);
    ten[p][15:0] = s ? (ten[p][15:0] | m) : (ten[p][15:0] & ~m);
    EN_OP_I <= 1'b1;
    EN_PRI_I <= p;
    EN_SET_I <= s;
    EN_MASK_I <= m;
    @(posedge CLK_I);
  endtask
  task automatic pulse(input logic p, input logic [13:0] c, input logic sw, input logic hw);
    swp = $urandom;
    CAUSE_PRI_I <= p;
    CAUSE_I <= c;
    SW_CAUSE_I <= sw;
    SW_CAUSE_BIT_I <= 4'h9;
    SCHED_HAS_WPTR_I <= hw;
    SCHED_WPTR_I <= swp;
    @(posedge CLK_I);
    CAUSE_I <= '0;
    SW_CAUSE_I <= 1'b0;
    SCHED_HAS_WPTR_I <= 1'b0;
    @(posedge CLK_I);
  endtask
  task automatic rd_status();
    apb(0, 12'h00c, 0, {17'h0, tst[0]});
    apb(0, 12'h010, 0, {17'h0, tst[1]});
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    @(posedge CLK_I);
    while (BUSY_O && k < 300) begin
      @(posedge CLK_I);
      k++;
    end
    `CHK("busy", 1'b0, BUSY_O);
    repeat (2) @(posedge CLK_I);
  endtask
  task automatic take(input logic p, input int c, input logic hw);
    logic [31:0] h, ip, wp, st, se;
    h = base + {23'h0, p, grp(c), 6'h0};
    ip = $urandom;
    wp = $urandom;
    st = $urandom;
    se = ten[p];
    wq.push_back({h + 32'h20, se});
    wq.push_back({h + 32'h24, st | (32'h1 << c)});
    wq.push_back({h + 32'h28, wp});
    wq.push_back({h + 32'h2c, ip});
    if (hw) wq.push_back({pat(h + 32'h8), swp});
    lq.push_back({pat(h + 32'hc), pat(h + 32'h8), pat(h + 32'h4), se & pat(h)});
    lq.push_back({ip, wp, st & ~(32'h1 << c) & ~32'h8000, se});
    PRI_I <= p;
    NEXT_IPTR_I <= ip;
    WPTR_I <= wp;
    STATUS_I <= st;
    TRAP_POINT_I <= 1'b1;
    @(posedge CLK_I);
    TRAP_POINT_I <= 1'b0;
    wait_idle();
    `CHK("group", grp(c), GROUP_O);
    `CHK("cause", c[3:0], CAUSE_O);
    TRET_I <= 1'b1;
    @(posedge CLK_I);
    TRET_I <= 1'b0;
    wait_idle();
    tst[p][c] = 1'b0;
    rd_status();
  endtask

  always @(posedge CLK_I) begin
    en_d <= EN_OP_I;
    if (PSEL_I && PENABLE_I && PREADY_O && !PWRITE_I)
      `CHK("prdata", rq.pop_front(), {PSLVERR_O, PRDATA_O});
    if (MEM_O.req && MEM_ACK_I && MEM_O.we)
      `CHK("mem_write", wq.pop_front(), {MEM_O.addr, MEM_O.wdata});
    if (LOAD_VALID_O) `CHK("load_state", lq.pop_front(), LOAD_STATE_O);
    if (en_d) `CHK("en_prev", pq.pop_front(), EN_PREV_O);
  end
  always @(posedge CLK_I) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial begin
    CLK_I = 1'b0;
    forever #10 CLK_I = ~CLK_I;
  end
  initial begin
    RESET_I = 1'b1;
    {PSEL_I, PENABLE_I, PWRITE_I, CAUSE_PRI_I, SW_CAUSE_I, SCHED_HAS_WPTR_I} = '0;
    {TRAP_POINT_I, PRI_I, TRET_I, EN_OP_I, EN_SET_I, EN_PRI_I} = '0;
    {PADDR_I, PWDATA_I, SW_CAUSE_BIT_I, SCHED_WPTR_I, NEXT_IPTR_I, WPTR_I} = '0;
    {STATUS_I, EN_MASK_I, CAUSE_I} = '0;
    void'($urandom(32'hec717565));
    repeat (2) @(posedge CLK_I);
    RESET_I <= 1'b0;
    @(posedge CLK_I);
    for (int i = 0; i < 6; i++) apb(0, 12'(4 * i), 0, 33'h0);
    apb(1, 12'h018, 32'hffffffff, 0);
    apb(0, 12'h018, 0, 33'h100000000);
    for (int i = 0; i < 6; i++) enop(1'($urandom), 1'($urandom), 16'($urandom));
    enop(0, 0, 16'hffff);
    enop(0, 1, 16'h3fff);
    enop(1, 0, 16'hffff);
    EN_OP_I <= 1'b0;
    apb(0, 12'h004, 0, {1'b0, ten[0]});
    apb(0, 12'h008, 0, {1'b0, ten[1]});
    for (int k = 0; k < 14; k++) begin
      PRI_I <= 1'($urandom);
      pulse(1'(k % 2), cv(k), 0, 0);
      if (k % 2 == 0) tst[0][k] = 1'b1;
      rd_status();
    end
    apb(1, 12'h00c, 32'hffff, 0);
    tst[0] = 16'h0;
    for (int k = 1; k < 14; k += 2) begin
      pulse(0, cv(k), 0, 0);
      tst[0][k] = 1'b1;
    end
    rd_status();
    apb(1, 12'h00c, 32'hffff, 0);
    pulse(0, 14'h0, 1, 0);
    pulse(1, 14'h0, 1, 0);
    tst[0] = 16'h8200;
    rd_status();
    apb(1, 12'h00c, 32'hffff, 0);
    enop(1, 1, 16'h3fff);
    EN_OP_I <= 1'b0;
    base = 32'h2000;
    apb(1, 12'h000, base, 0);
    tst[0] = 16'h0009;
    pulse(0, cv(0) | cv(3), 0, 0);
    take(0, 0, 0);
    take(0, 3, 0);
    for (int i = 0; i < 4; i++) begin
      tst[i % 2][cs[i]] = 1'b1;
      pulse(1'(i % 2), cv(cs[i]), 0, cs[i] == 7);
      take(1'(i % 2), cs[i], cs[i] == 7);
    end
    `CHK("left", 0, rq.size() + wq.size() + lq.size() + pq.size());
    tally_and_finish();
  end
endmodule
bind ctu_trap_unit ctu_trap_unit_properties u_props (.CLK_I, .RESET_I, .TRAP_POINT_I,
  .TRET_I, .PRI_I, .EN_OP_I, .EN_SET_I, .EN_PRI_I, .EN_MASK_I, .EN_PREV_O, .RD_BLOCK_O,
  .WR_BLOCK_O, .BUSY_O, .LOAD_VALID_O, .MEM_O, .MEM_ACK_I);
`default_nettype wire
